/* File: spio_port.sv */
// shared parallel port top: axi4-lite register slave, pad drive, analog routing.
// assumes pads and peripherals outside; pad input is asynchronous.
`timescale 1ns/10ps
module spio_port
(
   input  wire logic                       ref_clk_i,     // system clock 50 MHz
   input  wire logic                       nrst_i,        // async reset, low
   // axi4-lite slave
   input  wire logic [spio_pkg::ADDR_W-1:0] awaddr_i,     // write address
   input  wire logic                       awvalid_i,     // write address valid
   output logic                            awready_o,     // write address ready
   input  wire logic [31:0]                wdata_i,       // write data
   input  wire logic [3:0]                 wstrb_i,       // byte strobes
   input  wire logic                       wvalid_i,      // write data valid
   output logic                            wready_o,      // write data ready
   output logic [1:0]                      bresp_o,       // write response
   output logic                            bvalid_o,      // write response valid
   input  wire logic                       bready_i,      // write response ready
   input  wire logic [spio_pkg::ADDR_W-1:0] araddr_i,     // read address
   input  wire logic                       arvalid_i,     // read address valid
   output logic                            arready_o,     // read address ready
   output logic [31:0]                     rdata_o,       // read data
   output logic [1:0]                      rresp_o,       // read response
   output logic                            rvalid_o,      // read data valid
   input  wire logic                       rready_i,      // read data ready
   // pads
   input  wire logic [spio_pkg::PIN_W-1:0] pad_in_i,      // pad levels
   output logic      [spio_pkg::PIN_W-1:0] pad_out_o,     // pad drive data
   output logic      [spio_pkg::PIN_W-1:0] pad_oe_n_o,    // pad enable, low drives
   // peripherals
   input  wire logic [spio_pkg::PIN_W-1:0] per_active_i,  // peripheral driving pin
   input  wire logic [spio_pkg::PIN_W-1:0] per_out_i,     // peripheral pin data
   // converter
   output logic      [spio_pkg::PIN_W-1:0] adc_sel_o,     // pin routed to converter
   output logic      [spio_pkg::PIN_W-1:0] dig_in_en_o    // digital input buffer on
);
   //----------------------------------------------------------------
   // state
   //----------------------------------------------------------------
   typedef struct packed {
      spio_pkg::spio_regs_s       regs;
      logic                       aw_held;
      logic [spio_pkg::ADDR_W-1:0] aw_addr;
      logic                       w_held;
      logic [31:0]                w_data;
      logic [3:0]                 w_strb;
      logic                       bvalid;
      logic [1:0]                 bresp;
      logic                       rvalid;
      logic [31:0]                rdata;
      logic [1:0]                 rresp;
      spio_pkg::spio_pad_drv_s    drv;
   } spio_port_s;

   spio_port_s                 state_reg;
   spio_port_s                 state_next;
   logic [spio_pkg::PIN_W-1:0] pin_sync;
   logic [spio_pkg::PIN_W-1:0] pin_view;
   spio_pkg::spio_pad_drv_s    drv_comb;

   //----------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------
   // merge low 16 bits under byte strobes, masked to implemented bits
   function automatic logic [spio_pkg::PIN_W-1:0] strb_merge
   (
      input logic [spio_pkg::PIN_W-1:0] old_v,
      input logic [31:0]                data,
      input logic [3:0]                 strb
   );
      logic [spio_pkg::PIN_W-1:0] res;
      res = old_v;
      if (strb[0])
      begin
         res[7:0] = data[7:0];
      end
      if (strb[1])
      begin
         res[15:8] = data[15:8];
      end
      return res & spio_pkg::IMPL_MASK;
   endfunction

   function automatic logic addr_known(input logic [spio_pkg::ADDR_W-1:0] a);
      return (a == spio_pkg::OFS_DIRECTION) || (a == spio_pkg::OFS_PIN_VALUE) ||
             (a == spio_pkg::OFS_LATCH) || (a == spio_pkg::OFS_ANALOG) ||
             (a == spio_pkg::OFS_PERIPH_EN);
   endfunction

   //----------------------------------------------------------------
   // submodules
   //----------------------------------------------------------------
   spio_sync u_sync
   (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .async_i   (pad_in_i),
      .sync_o    (pin_sync)
   );

   spio_pad_mux u_mux
   (
      .direction_i  (state_reg.regs.direction_reg),
      .latch_i      (state_reg.regs.output_latch_reg),
      .per_en_i     (state_reg.regs.periph_enable_reg),
      .per_active_i (per_active_i),
      .per_out_i    (per_out_i),
      .drv_o        (drv_comb)
   );

   // analog pins read zero; pins still readable while peripheral drives
   assign pin_view = pin_sync & ~state_reg.regs.analog_pin_config_reg
                     & spio_pkg::IMPL_MASK;

   //----------------------------------------------------------------
   // next-state logic
   //----------------------------------------------------------------
   always_comb
   begin
      logic do_write;
      logic do_read;
      do_write   = 1'b0;
      do_read    = 1'b0;
      state_next = state_reg;
      state_next.drv = drv_comb;

      // address and data taken in either order, one write at a time
      if (awvalid_i && !state_reg.aw_held && !state_reg.bvalid)
      begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = awaddr_i;
      end
      if (wvalid_i && !state_reg.w_held && !state_reg.bvalid)
      begin
         state_next.w_held = 1'b1;
         state_next.w_data = wdata_i;
         state_next.w_strb = wstrb_i;
      end
      do_write = state_reg.aw_held && state_reg.w_held;

      if (do_write)
      begin
         state_next.aw_held = 1'b0;
         state_next.w_held  = 1'b0;
         state_next.bvalid  = 1'b1;
         state_next.bresp   = addr_known(state_reg.aw_addr) ?
                              spio_pkg::RESP_OKAY : spio_pkg::RESP_SLVERR;
         case (state_reg.aw_addr)
            spio_pkg::OFS_DIRECTION:
               state_next.regs.direction_reg = strb_merge(
                  state_reg.regs.direction_reg, state_reg.w_data, state_reg.w_strb);
            spio_pkg::OFS_PIN_VALUE, spio_pkg::OFS_LATCH:
               state_next.regs.output_latch_reg = strb_merge(
                  state_reg.regs.output_latch_reg, state_reg.w_data, state_reg.w_strb);
            spio_pkg::OFS_ANALOG:
               state_next.regs.analog_pin_config_reg = strb_merge(
                  state_reg.regs.analog_pin_config_reg, state_reg.w_data,
                  state_reg.w_strb);
            spio_pkg::OFS_PERIPH_EN:
               state_next.regs.periph_enable_reg = strb_merge(
                  state_reg.regs.periph_enable_reg, state_reg.w_data, state_reg.w_strb);
            default:
               state_next.bresp = spio_pkg::RESP_SLVERR;
         endcase
      end
      if (state_reg.bvalid && bready_i)
      begin
         state_next.bvalid = 1'b0;
      end

      // read answered one cycle after the address is taken
      do_read = arvalid_i && !state_reg.rvalid;
      if (do_read)
      begin
         state_next.rvalid = 1'b1;
         state_next.rresp  = spio_pkg::RESP_OKAY;
         case (araddr_i)
            spio_pkg::OFS_DIRECTION:
               state_next.rdata = {16'h0000, state_reg.regs.direction_reg};
            spio_pkg::OFS_PIN_VALUE:
               state_next.rdata = {16'h0000, pin_view};
            spio_pkg::OFS_LATCH:
               state_next.rdata = {16'h0000, state_reg.regs.output_latch_reg};
            spio_pkg::OFS_ANALOG:
               state_next.rdata = {16'h0000, state_reg.regs.analog_pin_config_reg};
            spio_pkg::OFS_PERIPH_EN:
               state_next.rdata = {16'h0000, state_reg.regs.periph_enable_reg};
            default:
            begin
               state_next.rdata = 32'h0000_0000;
               state_next.rresp = spio_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (state_reg.rvalid && rready_i)
      begin
         state_next.rvalid = 1'b0;
      end
   end

   //----------------------------------------------------------------
   // registers
   //----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg <= '0;
         state_reg.regs.direction_reg <= spio_pkg::RST_DIRECTION & spio_pkg::IMPL_MASK;
         state_reg.regs.output_latch_reg <= spio_pkg::RST_LATCH;
         state_reg.regs.analog_pin_config_reg <= spio_pkg::RST_ANALOG;
         state_reg.regs.periph_enable_reg <= spio_pkg::RST_PERIPH_EN;
         state_reg.drv.oe_n <= 16'hffff;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   //----------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------
   // pad drive is registered, so it trails a register write by one cycle
   assign pad_out_o  = state_reg.drv.out;
   assign pad_oe_n_o = state_reg.drv.oe_n;

   // converter sees analog-configured pins; output pins convert driven level,
   // digital inputs never reach it
   assign adc_sel_o   = state_reg.regs.analog_pin_config_reg
                        & spio_pkg::IMPL_MASK;
   assign dig_in_en_o = ~state_reg.regs.analog_pin_config_reg
                        & spio_pkg::IMPL_MASK;

   assign awready_o = !state_reg.aw_held && !state_reg.bvalid;
   assign wready_o  = !state_reg.w_held && !state_reg.bvalid;
   assign bvalid_o  = state_reg.bvalid;
   assign bresp_o   = state_reg.bresp;
   assign arready_o = !state_reg.rvalid;
   assign rvalid_o  = state_reg.rvalid;
   assign rdata_o   = state_reg.rdata;
   assign rresp_o   = state_reg.rresp;
endmodule

/* File: spio_pkg.sv */
// Function
// - every pin shareable between peripheral and port
// - active peripheral disables port driver, pin readable
// - idle enabled peripheral lets latch drive pin
// - direction, output latch, pin-value registers per pin
// - direction one means input, zero drives latch
// - reset sets every direction bit to input
// - latch read returns latch, write updates it
// - pin-value read gives pins, write updates latch
// - unimplemented bits disabled, all read zero
// - input-only shared pins act as dedicated pins
// - peripheral wins output data and enable muxes
// - analog config and direction jointly control pins
// - output-direction analog pin samples driven level
// - analog-configured pins read zero in pin-value
// - digital inputs never routed to the converter
//
// package for the shared parallel port: register map, widths, reset values, carriers.
// assumes an axi4-lite master on the system clock.
package spio_pkg;

   //----------------------------------------------------------------
   // widths
   //----------------------------------------------------------------
   localparam int unsigned PIN_W  = 16;
   localparam int unsigned ADDR_W = 5;

   //----------------------------------------------------------------
   // register offsets (byte addresses)
   //----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_DIRECTION = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_PIN_VALUE = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_LATCH     = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_ANALOG    = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_PERIPH_EN = 5'h10;

   //----------------------------------------------------------------
   // reset values and implemented-bit mask
   //----------------------------------------------------------------
   localparam logic [PIN_W-1:0] RST_DIRECTION = 16'hffff;
   localparam logic [PIN_W-1:0] RST_LATCH     = 16'h0000;
   localparam logic [PIN_W-1:0] RST_ANALOG    = 16'h0000;
   localparam logic [PIN_W-1:0] RST_PERIPH_EN = 16'h0000;
   localparam logic [PIN_W-1:0] IMPL_MASK     = 16'hffff;
   localparam logic [PIN_W-1:0] INPUT_ONLY    = 16'h0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   //----------------------------------------------------------------
   // carriers
   //----------------------------------------------------------------
   typedef struct packed {
      logic [PIN_W-1:0] direction_reg;
      logic [PIN_W-1:0] output_latch_reg;
      logic [PIN_W-1:0] analog_pin_config_reg;
      logic [PIN_W-1:0] periph_enable_reg;
   } spio_regs_s;

   typedef struct packed {
      logic [PIN_W-1:0] out;
      logic [PIN_W-1:0] oe_n;
   } spio_pad_drv_s;

endpackage

/* File: spio_sync.sv */
// two-flop synchroniser bank for pad levels.
// assumes inputs are asynchronous to ref_clk_i.
`timescale 1ns/10ps
module spio_sync
(
   input  wire logic                       ref_clk_i, // system clock
   input  wire logic                       nrst_i,    // async reset, low
   input  wire logic [spio_pkg::PIN_W-1:0] async_i,   // raw pad levels
   output logic      [spio_pkg::PIN_W-1:0] sync_o     // synchronised levels
);
   typedef struct packed {
      logic [spio_pkg::PIN_W-1:0] meta;
      logic [spio_pkg::PIN_W-1:0] stable;
   } spio_sync_s;

   spio_sync_s state_reg;
   spio_sync_s state_next;

   // first stage read only by the second
   always_comb
   begin
      state_next.meta   = async_i;
      state_next.stable = state_reg.meta;
   end

   // register stage
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign sync_o = state_reg.stable;
endmodule

/* File: spio_pad_mux.sv */
// per-pin ownership muxes between peripheral and port.
// assumes peripheral signals come from logic on the same clock.
`timescale 1ns/10ps
module spio_pad_mux
(
   input  wire logic [spio_pkg::PIN_W-1:0] direction_i,   // port direction, 1 = input
   input  wire logic [spio_pkg::PIN_W-1:0] latch_i,       // port latch
   input  wire logic [spio_pkg::PIN_W-1:0] per_en_i,      // peripheral enabled
   input  wire logic [spio_pkg::PIN_W-1:0] per_active_i,  // peripheral driving
   input  wire logic [spio_pkg::PIN_W-1:0] per_out_i,     // peripheral data
   output spio_pkg::spio_pad_drv_s         drv_o          // pad data and enable
);
   logic [spio_pkg::PIN_W-1:0] per_owns;

   // input-only functions never claim the pad, so such pins stay dedicated
   assign per_owns = per_en_i & per_active_i & ~spio_pkg::INPUT_ONLY
                     & spio_pkg::IMPL_MASK;

   // peripheral takes precedence on both muxes; unimplemented pins never driven
   always_comb
   begin
      drv_o.out  = (per_owns & per_out_i) | (~per_owns & latch_i);
      drv_o.oe_n = ~((per_owns) | (~per_owns & ~direction_i
                     & spio_pkg::IMPL_MASK));
   end
endmodule

/* File: spio_pad_model.sv */
// pad model for the shared port: resolves each pad from port drive and board source.
// assumes the bench supplies the board source; undriven pads carry a pull-up.
`timescale 1ns/10ps
module spio_pad_model
(
   input  wire logic [spio_pkg::PIN_W-1:0] pad_out_i,  // port drive data
   input  wire logic [spio_pkg::PIN_W-1:0] pad_oe_n_i, // port enable, low drives
   input  wire logic [spio_pkg::PIN_W-1:0] ext_en_i,   // board source active
   input  wire logic [spio_pkg::PIN_W-1:0] ext_val_i,  // board source level
   output logic      [spio_pkg::PIN_W-1:0] pad_o       // resolved pad level
);
   // driven pad shows its drive; released pad shows the board source if active, else pull-up, not last value
   assign pad_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & ~ext_en_i)
                | (pad_oe_n_i & ext_en_i & ext_val_i);
endmodule

/* File: spio_port_properties.sv */
// checker for the shared port: bus handshakes, reset drive, converter routing.
// assumes it is bound to spio_port and sees only its ports.
`timescale 1ns/10ps
module spio_port_properties
(
   input wire logic                       ref_clk_i,   // system clock
   input wire logic                       nrst_i,      // async reset, low
   input wire logic                       awvalid_i,   // write address valid
   input wire logic                       awready_o,   // write address ready
   input wire logic                       wvalid_i,    // write data valid
   input wire logic                       wready_o,    // write data ready
   input wire logic [1:0]                 bresp_o,     // write response
   input wire logic                       bvalid_o,    // write response valid
   input wire logic                       bready_i,    // write response ready
   input wire logic                       arvalid_i,   // read address valid
   input wire logic                       arready_o,   // read address ready
   input wire logic [31:0]                rdata_o,     // read data
   input wire logic [1:0]                 rresp_o,     // read response
   input wire logic                       rvalid_o,    // read valid
   input wire logic                       rready_i,    // read ready
   input wire logic [spio_pkg::PIN_W-1:0] pad_oe_n_o,  // pad enable
   input wire logic [spio_pkg::PIN_W-1:0] adc_sel_o,   // converter routing
   input wire logic [spio_pkg::PIN_W-1:0] dig_in_en_o  // digital buffer on
);
   //----------------------------------------------------------------
   // properties
   //----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   a_reset_inputs: assert property ($rose(nrst_i) |-> pad_oe_n_o == 16'hffff)
      else $error("pad driven right after reset");
   a_wr_answer: assert property (awvalid_i && awready_o && wvalid_i && wready_o |-> ##[1:2] bvalid_o)
      else $error("write response missing");
   a_wr_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
      else $error("write response dropped");
   a_rd_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
      else $error("read data missing");
   a_rd_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
      else $error("read data changed while waiting");
   a_upper_zero: assert property (rvalid_o |-> rdata_o[31:16] == 16'h0000)
      else $error("upper read bits set");
   a_err_data: assert property (rvalid_o && rresp_o == spio_pkg::RESP_SLVERR |-> rdata_o == 32'h0)
      else $error("error read carries data");
   a_route_split: assert property (dig_in_en_o == ~adc_sel_o)
      else $error("pin both digital and analog");
   a_wr_stall: assert property (bvalid_o |-> !awready_o && !wready_o)
      else $error("write taken while response pending");
endmodule

bind spio_port spio_port_properties i_spio_port_properties
(
   .ref_clk_i, .nrst_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o, .bresp_o, .bvalid_o,
   .bready_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .pad_oe_n_o,
   .adc_sel_o, .dig_in_en_o
);

/* File: spio_tb.sv */
// self-checking bench for the shared port: register access, pad ownership, analog reads.
// assumes the pad model closes the pad loop; all inputs change by nba after the edge.
`timescale 1ns/10ps
module testbench;
   logic        ref_clk = 0;
   logic        nrst = 0;
   logic [4:0]  awaddr = 0, araddr = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0;
   logic [3:0]  wstrb = 0;
   logic [15:0] per_active = 0, per_out = 0, ext_en = 0, ext_val = 0;
   wire  [15:0] pad_in, pad_out, pad_oe_n, adc_sel, dig_in_en;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   int          fails = 0, n_compared = 0;

   always #10 ref_clk = ~ref_clk;

   spio_port i_spio_port (.ref_clk_i(ref_clk), .nrst_i(nrst), .awaddr_i(awaddr),
      .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb),
      .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
      .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
      .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
      .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_n_o(pad_oe_n),
      .per_active_i(per_active), .per_out_i(per_out), .adc_sel_o(adc_sel),
      .dig_in_en_o(dig_in_en));
   spio_pad_model i_spio_pad_model (.pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad_in));

   //----------------------------------------------------------------
   // shared tasks
   //----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic wrc(input logic [4:0] a, input logic [15:0] d, input logic [3:0] s,
                      input logic [1:0] er);
      logic aw, w;
      aw = 0;
      w = 0;
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      do
      begin
         @(posedge ref_clk);
         if (awvalid && awready) begin aw = 1; awvalid <= 0; end
         if (wvalid && wready) begin w = 1; wvalid <= 0; end
      end while (!(aw && w));
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      // accept one cycle late, so the slave must hold its answer
      bready <= 1;
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      bready <= 0;
      chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
      @(posedge ref_clk);
   endtask

   task automatic rdc(input logic [4:0] a, input logic [1:0] er, input logic [15:0] e);
      araddr <= a;
      arvalid <= 1;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      // accept one cycle late, so the slave must hold its answer
      rready <= 1;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      rready <= 0;
      chk($sformatf("read %h", a), {14'h0, er, e}, {14'h0, rresp, rdata[15:0]});
      @(posedge ref_clk);
   endtask

   // pads are registered, then two sync flops before a read sees them
   task automatic settle;
      repeat (4) @(posedge ref_clk);
   endtask

   //----------------------------------------------------------------
   // scenarios
   //----------------------------------------------------------------
   task automatic t_reset;
      rdc(spio_pkg::OFS_DIRECTION, spio_pkg::RESP_OKAY, 16'hffff);
      rdc(spio_pkg::OFS_LATCH, spio_pkg::RESP_OKAY, 16'h0000);
      rdc(spio_pkg::OFS_ANALOG, spio_pkg::RESP_OKAY, 16'h0000);
      rdc(spio_pkg::OFS_PERIPH_EN, spio_pkg::RESP_OKAY, 16'h0000);
      chk("oe_n", 32'h0000ffff, {16'h0, pad_oe_n});
   endtask

   task automatic t_latch;
      wrc(spio_pkg::OFS_LATCH, 16'h1234, 4'h3, spio_pkg::RESP_OKAY);
      wrc(spio_pkg::OFS_DIRECTION, 16'h0000, 4'h3, spio_pkg::RESP_OKAY);
      settle();
      chk("pad_out", 32'h00001234, {16'h0, pad_out});
      chk("oe_n", 32'h00000000, {16'h0, pad_oe_n});
      wrc(spio_pkg::OFS_PIN_VALUE, 16'ha5c3, 4'h3, spio_pkg::RESP_OKAY);
      rdc(spio_pkg::OFS_LATCH, spio_pkg::RESP_OKAY, 16'ha5c3);
      wrc(spio_pkg::OFS_LATCH, 16'h00ff, 4'h1, spio_pkg::RESP_OKAY);
      settle();
      rdc(spio_pkg::OFS_PIN_VALUE, spio_pkg::RESP_OKAY, 16'ha5ff);
   endtask

   task automatic t_analog;
      ext_en <= 16'hffff;
      ext_val <= 16'h5a5a;
      wrc(spio_pkg::OFS_DIRECTION, 16'hffff, 4'h3, spio_pkg::RESP_OKAY);
      settle();
      rdc(spio_pkg::OFS_PIN_VALUE, spio_pkg::RESP_OKAY, 16'h5a5a);
      wrc(spio_pkg::OFS_ANALOG, 16'h00ff, 4'h3, spio_pkg::RESP_OKAY);
      settle();
      rdc(spio_pkg::OFS_PIN_VALUE, spio_pkg::RESP_OKAY, 16'h5a00);
      chk("dig_in_en", 32'h0000ff00, {16'h0, dig_in_en});
      wrc(spio_pkg::OFS_DIRECTION, 16'h0000, 4'h3, spio_pkg::RESP_OKAY);
      settle();
      chk("adc_sel", 32'h000000ff, {16'h0, adc_sel});
      chk("oe_n", 32'h00000000, {16'h0, pad_oe_n});
      rdc(spio_pkg::OFS_PIN_VALUE, spio_pkg::RESP_OKAY, 16'ha500);
      wrc(spio_pkg::OFS_ANALOG, 16'h0000, 4'h3, spio_pkg::RESP_OKAY);
   endtask

   task automatic t_periph;
      wrc(spio_pkg::OFS_LATCH, 16'hffff, 4'h3, spio_pkg::RESP_OKAY);
      wrc(spio_pkg::OFS_PERIPH_EN, 16'h000f, 4'h3, spio_pkg::RESP_OKAY);
      per_active <= 16'h0003;
      per_out <= 16'h0001;
      settle();
      chk("pad_out", 32'h0000fffd, {16'h0, pad_out});
      rdc(spio_pkg::OFS_PIN_VALUE, spio_pkg::RESP_OKAY, 16'hfffd);
      per_active <= 16'h0000;
      settle();
      chk("pad_out", 32'h0000ffff, {16'h0, pad_out});
      wrc(spio_pkg::OFS_DIRECTION, 16'hffff, 4'h3, spio_pkg::RESP_OKAY);
      per_active <= 16'h0003;
      settle();
      chk("oe_n", 32'h0000fffc, {16'h0, pad_oe_n});
   endtask

   // a second reset in mid-run must return every pin to input
   task automatic t_rereset;
      wrc(spio_pkg::OFS_DIRECTION, 16'h0000, 4'h3, spio_pkg::RESP_OKAY);
      settle();
      nrst <= 0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1;
      @(posedge ref_clk);
      chk("oe_n", 32'h0000ffff, {16'h0, pad_oe_n});
      rdc(spio_pkg::OFS_DIRECTION, spio_pkg::RESP_OKAY, 16'hffff);
      rdc(spio_pkg::OFS_PERIPH_EN, spio_pkg::RESP_OKAY, 16'h0000);
   endtask

   task automatic t_unmapped;
      rdc(5'h14, spio_pkg::RESP_SLVERR, 16'h0000);
      wrc(5'h18, 16'h0001, 4'h3, spio_pkg::RESP_SLVERR);
   endtask

   //----------------------------------------------------------------
   // run control
   //----------------------------------------------------------------
   task automatic end_sim;
      if (fails == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // watchdog sized well above the few hundred cycles the scenarios need
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      fails++;
      end_sim();
   end

   initial
   begin
      repeat (8) @(posedge ref_clk);
      nrst <= 1;
      @(posedge ref_clk);
      t_reset();
      t_latch();
      t_analog();
      t_periph();
      t_rereset();
      t_unmapped();
      end_sim();
   end
endmodule
